/* logic/lcg_group.sv */
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
`include "lcg_regs.svh"

// Contract
// [R01] The group holds exactly eight cells sharing inputs, wiring and control lines.
// [R02] Four group control lines reach every cell of the group.
// [R03] Lines zero and one act as clocks, lines two and three as clear/preset.
// [R04] Up to four global control signals feed the control lines.
// [R05] A control line may instead be driven by any cell output.
// [R06] Each lookup table computes any function of four data inputs.
// [R07] Each register works as D, T, JK or SR flipflop.
// [R08] Bypass routes the lookup table result straight to the cell output.
// [R09] The cascade chain leaves the last cell and enters the next group's first.
// [R10] Chained cells combine results so n cells cover 4n inputs.
// [R11] Each cell runs in one of four operating modes.
// [R12] Data, feedback, carry-in and cascade-in are steered by the mode.
// [R13] Clock, clear and preset of each register come from dedicated controls; the code uses the group control lines.
// [R14] Clear driven low by a group line forces the register to zero.
// [R15] First line with third data input high loads a one, a preset.
// [R16] Preset through clear by inverting register input and output, freeing third input.
// [R17] With both clear and preset, first line presets and second line clears.
// [R18] Load with clear: first line loads third data input, second line clears.
// [R19] Clear beats preset or load when asserted together.
module lcg_group #(
  parameter int CELLS = `LCG_CELLS_N
) (
  input  wire logic        CLK,          // System clock.
  input  wire logic        RST_N,        // Asynchronous reset, active low.
  input  wire logic [3:0]  REG_ADDR,     // Register address.
  input  wire logic [31:0] REG_WDATA,    // Register write data.
  input  wire logic        REG_WR,       // Write strobe.
  input  wire logic        REG_RD,       // Read strobe.
  output logic      [31:0] REG_RDATA,    // Read data, one cycle after the strobe.
  input  wire logic [3:0]  GLOBAL_CTRL,  // Dedicated global control pins.
  input  wire logic [31:0] DATA_IN,      // Four data inputs per cell, cell 0 lowest.
  input  wire logic        CARRY_IN,     // Carry into cell 0.
  input  wire logic        CASCADE_IN,   // Cascade from the previous group.
  output logic      [7:0]  CELL_OUT,     // Cell outputs.
  output logic             CARRY_OUT,    // Carry out of cell 7.
  output logic             CASCADE_OUT   // Cascade to the next group.
);

  // ============================================================
  // Decoding shared by the write path and the cells.
  function automatic lcg_pkg::lcg_cfg_type to_cfg(input logic [31:0] w);
    lcg_pkg::lcg_cfg_type c;
    c.lookup_table     = w[`LCG_F_LUT +: 16];
    c.ff      = lcg_pkg::lcg_ff_type'(w[`LCG_F_FF +: 2]);
    c.mode    = lcg_pkg::lcg_mode_type'(w[`LCG_F_MODE +: 2]);
    c.bypass  = w[`LCG_F_BYP];
    c.casc    = lcg_pkg::lcg_casc_type'(w[`LCG_F_CASC +: 2]);
    c.clk_sel = w[`LCG_F_CLK];
    c.clr_sel = w[`LCG_F_CLR];
    c.asy     = lcg_pkg::lcg_async_type'(w[`LCG_F_ASY +: 3]);
    return c;
  endfunction

  function automatic logic lut_eval(input logic [15:0] mask, input logic [3:0] idx);
    return mask[idx];
  endfunction

  // ============================================================
  // Register file.
  lcg_pkg::lcg_cfg_type cfg_r   [8];
  lcg_pkg::lcg_cfg_type cfg_nxt [8];
  logic [15:0]          csrc_r;
  logic [15:0]          csrc_nxt;
  logic [31:0]          rdata_r;
  logic [31:0]          rdata_nxt;
  logic [7:0]           qlog;
  logic [7:0]           cell_out;

  always_comb begin
    csrc_nxt  = csrc_r;
    rdata_nxt = 32'h00000000;
    for (int k = 0; k < 8; k++) begin
      cfg_nxt[k] = cfg_r[k];
    end
    if (REG_WR) begin
      if (REG_ADDR <= `LCG_ADDR_CFG7) begin
        cfg_nxt[REG_ADDR[2:0]] = to_cfg(REG_WDATA);
      end else if (REG_ADDR == `LCG_ADDR_CSRC) begin
        csrc_nxt = REG_WDATA[15:0];
      end
    end
    if (REG_RD) begin
      if (REG_ADDR <= `LCG_ADDR_CFG7) begin
        rdata_nxt = {4'h0, cfg_r[REG_ADDR[2:0]]};
      end else if (REG_ADDR == `LCG_ADDR_CSRC) begin
        rdata_nxt = {16'h0000, csrc_r};
      end else if (REG_ADDR == `LCG_ADDR_STAT) begin
        rdata_nxt = {16'h0000, qlog, cell_out};
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int k = 0; k < 8; k++) begin
        cfg_r[k] <= `LCG_CFG_RST;
      end
      csrc_r  <= `LCG_CSRC_RST;
      rdata_r <= 32'h00000000;
    end else begin
      for (int k = 0; k < 8; k++) begin
        cfg_r[k] <= cfg_nxt[k];
      end
      csrc_r  <= csrc_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign REG_RDATA = rdata_r;

  // ============================================================
  // Control lines: synchronised global pins or cell outputs.
  logic [3:0] gsync1_r;
  logic [3:0] gsync2_r;
  logic [3:0] line_r;
  logic [3:0] line_nxt;
  logic [3:0] prev_r;
  logic [1:0] clk_en;

  always_comb begin
    for (int k = 0; k < 4; k++) begin
      if (csrc_r[4*k+3]) begin
        line_nxt[k] = cell_out[csrc_r[4*k +: 3]]; // [R05]
      end else begin
        line_nxt[k] = gsync2_r[csrc_r[4*k +: 2]]; // [R04]
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      gsync1_r <= 4'h0;
      gsync2_r <= 4'h0;
      line_r   <= 4'h0;
      prev_r   <= 4'h0;
    end else begin
      gsync1_r <= GLOBAL_CTRL;
      gsync2_r <= gsync1_r;
      line_r   <= line_nxt; // [R02]
      prev_r   <= line_r;
    end
  end

  // Lines 0 and 1 become clock enables on their rising edges.
  assign clk_en = line_r[1:0] & ~prev_r[1:0]; // [R03]

  // ============================================================
  // Cells and their carry and cascade chains.
  logic [8:0] carry;
  logic [8:0] casc;
  logic [7:0] q_r;
  logic [7:0] q_nxt;

  assign carry[0] = CARRY_IN;
  assign casc[0]  = CASCADE_IN;

  generate
    for (genvar i = 0; i < 8; i++) begin : g_cell // [R01]
      lcg_pkg::lcg_cfg_type c;
      logic [3:0] d;
      logic       fb;
      logic       raw;
      logic       f;
      logic       cout;
      logic       ce;
      logic       nxt;
      logic       lv;
      logic       first;
      logic       second;
      logic       register_clear_low;
      logic       load;
      logic       inv;

      assign c      = cfg_r[i];
      assign d      = DATA_IN[4*i +: 4];
      assign inv    = (c.asy == lcg_pkg::ASY_PRE_INV);
      assign fb     = q_r[i] ^ inv; // [R16]
      assign first  = line_r[2];
      assign second = line_r[3];

      always_comb begin
        raw  = 1'b0;
        cout = 1'b0;
        case (c.mode) // [R11]
          lcg_pkg::MODE_NORMAL: begin
            raw = lut_eval(c.lookup_table, d); // [R06]
          end
          lcg_pkg::MODE_ARITH: begin
            raw  = lut_eval(c.lookup_table, {1'b0, carry[i], d[1:0]}); // [R12]
            cout = lut_eval(c.lookup_table, {1'b1, carry[i], d[1:0]});
          end
          lcg_pkg::MODE_UPDN, lcg_pkg::MODE_CLRCNT: begin
            raw  = lut_eval(c.lookup_table, {1'b0, carry[i], d[1], fb}); // [R12]
            cout = lut_eval(c.lookup_table, {1'b1, carry[i], d[1], fb});
          end
          default: begin
            raw = 1'b0;
          end
        endcase
        case (c.casc) // [R10]
          lcg_pkg::CASC_AND: f = raw & casc[i];
          lcg_pkg::CASC_OR:  f = raw | casc[i];
          default:           f = raw;
        endcase
      end

      always_comb begin
        ce = clk_en[c.clk_sel]; // [R13]
        case (c.ff) // [R07]
          lcg_pkg::FF_D:  nxt = f;
          lcg_pkg::FF_T:  nxt = fb ^ f;
          lcg_pkg::FF_JK: nxt = (f & ~fb) | (~d[3] & fb);
          lcg_pkg::FF_SR: nxt = f | (fb & ~d[3]);
          default:        nxt = fb;
        endcase
        if (c.mode == lcg_pkg::MODE_CLRCNT && d[2]) begin
          nxt = 1'b0;
        end
        register_clear_low = 1'b1;
        load = 1'b0;
        case (c.asy)
          lcg_pkg::ASY_CLEAR: begin
            register_clear_low = ~(c.clr_sel ? second : first); // [R14]
          end
          lcg_pkg::ASY_PRE_LOAD, lcg_pkg::ASY_LOAD: begin
            load = first; // [R15]
          end
          lcg_pkg::ASY_PRE_INV: begin
            register_clear_low = ~(c.clr_sel ? second : first); // [R16]
          end
          lcg_pkg::ASY_CLR_PRE, lcg_pkg::ASY_LOAD_CLR: begin
            load               = first; // [R17]
            register_clear_low = ~second; // [R18]
          end
          default: begin
            load = 1'b0;
          end
        endcase
        // Stored bit is inverted in the inverting scheme, so clearing it presets the output.
        if (!register_clear_low) begin
          lv = inv; // [R19]
        end else if (load) begin
          lv = (c.asy == lcg_pkg::ASY_CLR_PRE) ? 1'b1 : d[3]; // [R15]
        end else if (ce) begin
          lv = nxt;
        end else begin
          lv = fb;
        end
        q_nxt[i] = lv ^ inv; // [R16]
      end

      assign qlog[i]     = fb;
      assign cell_out[i] = c.bypass ? f : fb; // [R08]
      assign carry[i+1]  = cout;
      assign casc[i+1]   = f;
    end
  endgenerate

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      q_r <= 8'h00;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign CELL_OUT    = cell_out;
  assign CARRY_OUT   = carry[8];
  assign CASCADE_OUT = casc[8]; // [R09]

endmodule

/* logic/lcg_pkg.sv */
package lcg_pkg;

  typedef enum logic [1:0] {FF_D, FF_T, FF_JK, FF_SR} lcg_ff_type;

  typedef enum logic [1:0] {MODE_NORMAL, MODE_ARITH, MODE_UPDN, MODE_CLRCNT} lcg_mode_type;

  typedef enum logic [1:0] {CASC_OFF, CASC_AND, CASC_OR, CASC_RSVD} lcg_casc_type;

  typedef enum logic [2:0] {
    ASY_NONE,
    ASY_CLEAR,
    ASY_PRE_LOAD,
    ASY_PRE_INV,
    ASY_CLR_PRE,
    ASY_LOAD_CLR,
    ASY_LOAD,
    ASY_RSVD
  } lcg_async_type;

  typedef struct packed {
    lcg_async_type asy;
    logic          clr_sel;
    logic          clk_sel;
    lcg_casc_type  casc;
    logic          bypass;
    lcg_mode_type  mode;
    lcg_ff_type    ff;
    logic [15:0]   lookup_table;
  } lcg_cfg_type;

endpackage

/* logic/lcg_regs.svh */
`ifndef LCG_REGS_SVH
`define LCG_REGS_SVH

// ============================================================
// Register map of the cell group.
`define LCG_ADDR_CFG0  4'h0
`define LCG_ADDR_CFG7  4'h7
`define LCG_ADDR_CSRC  4'h8
`define LCG_ADDR_STAT  4'h9

// ============================================================
// Field positions inside a cell configuration word.
`define LCG_F_LUT      0
`define LCG_F_FF       16
`define LCG_F_MODE     18
`define LCG_F_BYP      20
`define LCG_F_CASC     21
`define LCG_F_CLK      23
`define LCG_F_CLR      24
`define LCG_F_ASY      25
`define LCG_CFG_BITS   28

// ============================================================
// Sizes.
`define LCG_CELLS_N    8

// ============================================================
// Reset values.
`define LCG_CFG_RST    28'h0000000
`define LCG_CSRC_RST   16'h3210

`endif

/* testbench/lcg_group_checker.sv */
`timescale 1ns/1ps
module lcg_group_checker (
  input wire logic        CLK,          // Clock.
  input wire logic        RST_N,        // Reset, active low.
  input wire logic [3:0]  REG_ADDR,     // Address.
  input wire logic [31:0] REG_WDATA,    // Write data.
  input wire logic        REG_WR,       // Write strobe.
  input wire logic [3:0]  GLOBAL_CTRL,  // Control pins.
  input wire logic [31:0] DATA_IN,      // Cell data.
  input wire logic [7:0]  CELL_OUT      // Cell outputs.
);
  // ============================================================
  // Shadow of the cell 0 configuration word.
  logic [27:0] cfg_r;
  logic        reg_on;
  logic        f0;
  assign reg_on = !cfg_r[20];
  assign f0 = cfg_r[DATA_IN[3:0]];
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) cfg_r <= 28'h0000000;
    else if (REG_WR && REG_ADDR == 4'h0) cfg_r <= REG_WDATA[27:0];
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  property p_byp; cfg_r[22:18] == 5'h04 |-> CELL_OUT[0] == f0; endproperty
  a_byp: assert property (p_byp) else $error("bypass output wrong");
  property p_dff; $rose(GLOBAL_CTRL[0]) && cfg_r[27:16] == 12'h0 ##3 cfg_r[27:16] == 12'h0 |=> CELL_OUT[0] == $past(f0);
  endproperty
  a_dff: assert property (p_dff) else $error("d register wrong");
  property p_clr; (reg_on && cfg_r[27:24] == 4'h2 && GLOBAL_CTRL[2])[*4] |=> !CELL_OUT[0]; endproperty
  a_clr: assert property (p_clr) else $error("clear failed");
  property p_pld; (reg_on && cfg_r[27:25] == 3'h2 && GLOBAL_CTRL[2] && DATA_IN[3])[*4] |=> CELL_OUT[0]; endproperty
  a_pld: assert property (p_pld) else $error("preset by load failed");
  property p_pinv; (reg_on && cfg_r[27:24] == 4'h6 && GLOBAL_CTRL[2])[*4] |=> CELL_OUT[0]; endproperty
  a_pinv: assert property (p_pinv) else $error("preset by inversion failed");
  property p_pre; (reg_on && cfg_r[27:25] == 3'h4 && GLOBAL_CTRL[3:2] == 2'b01)[*4] |=> CELL_OUT[0]; endproperty
  a_pre: assert property (p_pre) else $error("preset failed");
  property p_both; (reg_on && cfg_r[27:25] == 3'h4 && GLOBAL_CTRL[3:2] == 2'b11)[*4] |=> !CELL_OUT[0]; endproperty
  a_both: assert property (p_both) else $error("clear lost to preset");
  property p_ld; (reg_on && cfg_r[27:25] == 3'h5 && GLOBAL_CTRL[3:2] == 2'b01)[*4] |=> CELL_OUT[0] == $past(DATA_IN[3]);
  endproperty
  a_ld: assert property (p_ld) else $error("load failed");
endmodule

bind lcg_group lcg_group_checker lcg_group_checker_i (.CLK(CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .GLOBAL_CTRL(GLOBAL_CTRL), .DATA_IN(DATA_IN), .CELL_OUT(CELL_OUT));

/* testbench/lcg_neighbor.sv */
`timescale 1ns/1ps
module lcg_neighbor (
  input  wire logic       CLK,        // Clock.
  input  wire logic [3:0] nb_data,    // Data of the previous group's last cell.
  output logic            casc_out,   // Cascade into the next group.
  output logic            carry_out   // Carry into the next group.
);
  // ============================================================
  // Last cell of the previous group, a four-input AND on the chain.
  always_ff @(posedge CLK) begin
    casc_out  <= &nb_data;
    carry_out <= nb_data[0];
  end
endmodule

/* testbench/logic_array_block_cell_bench.sv */
`timescale 1ns/1ps
module logic_array_block_cell_bench;
  logic        CLK, RST_N, REG_WR, REG_RD, CARRY_IN, CASCADE_IN;
  logic [3:0]  REG_ADDR, GLOBAL_CTRL, nb_data;
  logic [31:0] REG_WDATA, DATA_IN, REG_RDATA;
  logic [7:0]  CELL_OUT;
  logic        CARRY_OUT, CASCADE_OUT;
  int          error_cnt = 0;
  int          check_count = 0;

  lcg_group lcg_group_i (.CLK(CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .GLOBAL_CTRL(GLOBAL_CTRL), .DATA_IN(DATA_IN),
    .CARRY_IN(CARRY_IN), .CASCADE_IN(CASCADE_IN), .CELL_OUT(CELL_OUT), .CARRY_OUT(CARRY_OUT),
    .CASCADE_OUT(CASCADE_OUT));
  lcg_neighbor lcg_neighbor_i (.CLK(CLK), .nb_data(nb_data), .casc_out(CASCADE_IN), .carry_out(CARRY_IN));

  // ============================================================
  // Access and check tasks.
  task automatic test_done();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge CLK);
    REG_WR    <= 1'b1;
    REG_ADDR  <= a;
    REG_WDATA <= d;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge CLK);
    REG_RD   <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1 chk(REG_RDATA, exp);
  endtask
  task automatic ctl(input logic [3:0] c, input int n);
    @(posedge CLK);
    GLOBAL_CTRL <= c;
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic step(input logic [31:0] cfg, input logic [3:0] d, input logic [3:0] c, input logic e);
    wr(4'h0, cfg);
    DATA_IN <= {28'h0, d};
    ctl(c, 5);
    chk({31'h0, CELL_OUT[0]}, {31'h0, e});
    ctl(4'h0, 3);
  endtask

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  initial begin
    #300000;
    error_cnt++;
    test_done();
  end

  // ============================================================
  // Main sequence.
  initial begin
    RST_N = 1'b0;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_ADDR = 4'h0;
    REG_WDATA = 32'h0;
    GLOBAL_CTRL = 4'h0;
    DATA_IN = 32'h0;
    nb_data = 4'h0;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    rd(4'h8, 32'h00003210);
    rd(4'h0, 32'h00000000);
    rd(4'ha, 32'h00000000);
    wr(4'h7, 32'h0010ffff);
    rd(4'h7, 32'h0010ffff);
    chk({31'h0, CELL_OUT[7]}, 32'h1);
    chk({31'h0, CASCADE_OUT}, 32'h1);
    chk({31'h0, CARRY_OUT}, 32'h0);
    wr(4'h0, 32'h00108000);
    for (int i = 0; i < 16; i++) begin
      DATA_IN <= {28'h0, i[3:0]};
      @(posedge CLK);
      #1 chk({31'h0, CELL_OUT[0]}, {31'h0, i == 15});
    end
    wr(4'h0, 32'h00308000);
    nb_data <= 4'hf;
    repeat (2) @(posedge CLK);
    #1 chk({31'h0, CELL_OUT[0]}, 32'h1);
    nb_data <= 4'h7;
    repeat (2) @(posedge CLK);
    #1 chk({31'h0, CELL_OUT[0]}, 32'h0);
    step(32'h0000ff00, 4'h8, 4'h1, 1'b1);
    step(32'h0000ff00, 4'h0, 4'h1, 1'b0);
    step(32'h0000ff00, 4'h8, 4'h1, 1'b1);
    step(32'h0001ff00, 4'h8, 4'h1, 1'b0);
    step(32'h0002ff00, 4'h8, 4'h1, 1'b1);
    step(32'h0003ff00, 4'h8, 4'h1, 1'b1);
    step(32'h0200ff00, 4'h8, 4'h4, 1'b0);
    step(32'h0400ff00, 4'h8, 4'h4, 1'b1);
    step(32'h0800ff00, 4'h0, 4'h8, 1'b0);
    step(32'h0800ff00, 4'h0, 4'h4, 1'b1);
    step(32'h0800ff00, 4'h0, 4'hc, 1'b0);
    step(32'h0a00ff00, 4'h8, 4'h4, 1'b1);
    step(32'h0a00ff00, 4'h0, 4'h4, 1'b0);
    step(32'h0600ff00, 4'h0, 4'h1, 1'b0);
    step(32'h0600ff00, 4'h0, 4'h4, 1'b1);
    rd(4'h9, 32'h00008181);
    test_done();
  end
endmodule
